// >>> core/femc_pkg.sv
package femc_pkg;

  // Register bus geometry
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;

  // Relative addresses
  localparam logic [5:0] ADDR_ANA_FIRST = 6'h08;
  localparam logic [5:0] ADDR_ANA_EXT   = 6'h18;
  localparam logic [5:0] ADDR_ANA_LAST  = 6'h1f;
  localparam logic [5:0] ADDR_CRYO      = 6'h20;
  localparam logic [5:0] ADDR_DMON      = 6'h21;
  localparam logic [5:0] ADDR_CAL       = 6'h22;
  localparam logic [5:0] ADDR_IDWORD    = 6'h23;
  localparam logic [5:0] ADDR_SERIAL    = 6'h24;

  // Cryogenic state codes
  localparam logic [2:0] CRYO_RESET  = 3'h0;
  localparam logic [2:0] CRYO_COOL   = 3'h7;
  localparam logic [2:0] CRYO_STRESS = 3'h4;
  localparam logic [2:0] CRYO_OFF    = 3'h5;
  localparam logic [2:0] CRYO_HEAT   = 3'h2;
  localparam logic [2:0] CRYO_PUMP   = 3'h6;

  // Calibrator command bits
  localparam int CAL_W       = 8;
  localparam int CAL_LO_MOD  = 0;
  localparam int CAL_LO_CONT = 1;
  localparam int CAL_HI_MOD  = 2;
  localparam int CAL_HI_CONT = 3;
  localparam logic [7:0] CAL_RESET = 8'h00;

  // Digital monitor word field positions
  localparam int DMON_CRYO_LSB = 0;
  localparam int DMON_SRC_BIT  = 3;
  localparam int DMON_PUMP_BIT = 4;
  localparam int DMON_VALV_BIT = 5;

  // Identity word field positions
  localparam int ID_BAND_LSB = 0;
  localparam int ID_MOD_LSB  = 4;
  localparam int ID_SER_LSB  = 6;

  // Serial number strap width
  localparam int SN_W = 8;

  // Front-end monitor lines, sampled as one bundle
  typedef struct packed {
    logic [2:0] cryo_state_monitor;
    logic       control_source_in;
    logic       pump_request_in;
    logic       valve_position_in;
    logic [3:0] band_id_bits;
    logic [5:0] fe_serial_bits;
    logic [1:0] fe_mod_level_bits;
    logic       id_parity;
    logic       cal_mod_signal;
  } femc_mon_t;

  // Analog multiplexer selection
  typedef struct packed {
    logic [3:0] int_chan;
    logic       ext_path;
    logic [2:0] ext_chan;
  } femc_ana_sel_t;

endpackage : femc_pkg

// >>> core/femc_frontend_monitor_control.sv
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/100ps
// Notes on behaviour
// - Commands arrive from host pair; monitor data returns on the receive pair.
// - Handshake and decode address; only own locations acknowledge.
// - Serial number location returns strap-wired module serial number.
// - Cryo state latch reads back exactly the last written value.
// - Calibrator command latched and readable at its own location.
// - Latched cryo state drives three control outputs.
// - Three cryo state monitor inputs are sampled for host verification.
// - Front-end status inputs captured in readable digital monitor latch.
// - Valve input low reads closed, high reads open.
// - Pump request input low reads off, high reads requested.
// - Control source input low reads manual, high reads computer.
// - Band, serial and modification lines form one 12-bit identity value.
// - Identity latch returns band bits, parity and hard-wired type bits.
// - Calibrator command decoded into low and high drive enables.
// - Modulated modes AND the selected drive with the modulation input.
// - Analog address selects one of 16 inputs onto the output.
// - Three select outputs route one of 8 external analog inputs.
// - Power-up clears all command latches: cryo state 000 (CRYO_RESET), calibrators off.
// - Cryo codes: 111 cool, 100 stress, 101 off, 010 heat, 110 pump.
// - Calibrator codes 0,2,1,8,4 accepted and read back.
// - Monitor word: cryo bits 0-2, source 3, pump 4, valve 5.
// - Identity word: band 0-3, modification 4-5, serial 6-11.
module femc_frontend_monitor_control
  import femc_pkg::*;
#(
  parameter logic [2:0] ID_TYPE_CODE = 3'h5  // Arbitrary module-type marker
)
(
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  // Register port from the interface board
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire logic [DATA_W-1:0]   reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [DATA_W-1:0]   reg_rdata,
  output logic                     reg_ack,
  // Identity read handshake from the interface board
  input  wire logic                id_read_req,
  output logic      [7:0]          id_read_data,
  output logic                     id_read_ack,
  // Backplane serial number straps
  input  wire logic [SN_W-1:0]     sn_strap,
  // Front-end monitor lines
  input  wire femc_mon_t           fe_mon_in,
  // Front-end control outputs
  output logic      [2:0]          cryo_state_bits,
  output logic                     low_cal_drive,
  output logic                     high_cal_drive,
  // Analog multiplexer selection
  output logic      [3:0]          ana_mux_sel,
  output logic                     ana_ext_path,
  output logic      [2:0]          ext_mux_select
);

  femc_mon_t           mon_meta_reg;
  femc_mon_t           mon_sync_reg;
  logic [SN_W-1:0]     sn_meta_reg;
  logic [SN_W-1:0]     sn_sync_reg;
  logic [SN_W-1:0]     sn_reg;
  logic [1:0]          sn_wait_reg;
  logic [2:0]          cryo_reg;
  logic [CAL_W-1:0]    cal_reg;
  logic [5:0]          dmon_reg;
  logic [11:0]         idword_reg;
  femc_ana_sel_t       ana_sel_reg;
  femc_ana_sel_t       ana_sel_next;
  logic [DATA_W-1:0]   rdata_reg;
  logic [DATA_W-1:0]   rdata_next;
  logic                ack_reg;
  logic                ack_next;
  logic [7:0]          idrd_reg;
  logic                idack_reg;
  logic                low_drv_reg;
  logic                high_drv_reg;
  logic                hit_own;
  logic                hit_ana;
  logic [5:0]          ana_offset;

  // Two-stage synchroniser for every front-end line; the first stage feeds nothing else
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mon_meta_reg <= '0;
      mon_sync_reg <= '0;
    end
    else
    begin
      mon_meta_reg <= fe_mon_in;
      mon_sync_reg <= mon_meta_reg;
    end
  end

  // Straps are static but still cross in through two stages
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sn_meta_reg <= '0;
      sn_sync_reg <= '0;
    end
    else
    begin
      sn_meta_reg <= sn_strap;
      sn_sync_reg <= sn_meta_reg;
    end
  end

  // Serial number caught once the synchroniser has filled after reset release
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sn_wait_reg <= 2'h0;
      sn_reg      <= '0;
    end
    else if (sn_wait_reg != 2'h3)
    begin
      sn_wait_reg <= sn_wait_reg + 2'h1;
      if (sn_wait_reg == 2'h2)
      begin
        sn_reg <= sn_sync_reg;
      end
    end
  end

  // Address decode
  always_comb
  begin
    hit_ana = (reg_addr >= ADDR_ANA_FIRST) && (reg_addr <= ADDR_ANA_LAST);
    hit_own = hit_ana ||
              (reg_addr == ADDR_CRYO)   ||
              (reg_addr == ADDR_DMON)   ||
              (reg_addr == ADDR_CAL)    ||
              (reg_addr == ADDR_IDWORD) ||
              (reg_addr == ADDR_SERIAL);
    ana_offset = reg_addr - ADDR_ANA_FIRST;
  end

  // Cryogenic state command latch; reset value gives the start-up state
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cryo_reg <= CRYO_RESET;
    end
    else if (reg_wr && (reg_addr == ADDR_CRYO))
    begin
      cryo_reg <= reg_wdata[2:0];
    end
  end

  // Calibrator command latch; all codes stored verbatim for readback
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cal_reg <= CAL_RESET;
    end
    else if (reg_wr && (reg_addr == ADDR_CAL))
    begin
      cal_reg <= reg_wdata[CAL_W-1:0];
    end
  end

  // Digital monitor latch: 0 = closed/off/manual, 1 = open/requested/computer
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dmon_reg <= '0;
    end
    else
    begin
      dmon_reg[DMON_CRYO_LSB +: 3] <= mon_sync_reg.cryo_state_monitor;
      dmon_reg[DMON_SRC_BIT]       <= mon_sync_reg.control_source_in;
      dmon_reg[DMON_PUMP_BIT]      <= mon_sync_reg.pump_request_in;
      dmon_reg[DMON_VALV_BIT]      <= mon_sync_reg.valve_position_in;
    end
  end

  // Identity word assembled from the twelve identity lines
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idword_reg <= '0;
    end
    else
    begin
      idword_reg[ID_BAND_LSB +: 4] <= mon_sync_reg.band_id_bits;
      idword_reg[ID_MOD_LSB +: 2]  <= mon_sync_reg.fe_mod_level_bits;
      idword_reg[ID_SER_LSB +: 6]  <= mon_sync_reg.fe_serial_bits;
    end
  end

  // Identity read latch; parity is passed through as supplied by the front end
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idrd_reg  <= '0;
      idack_reg <= 1'b0;
    end
    else
    begin
      idack_reg <= id_read_req;
      if (id_read_req)
      begin
        idrd_reg <= {ID_TYPE_CODE, mon_sync_reg.id_parity,
                     mon_sync_reg.band_id_bits};
      end
    end
  end

  // Calibrator drive decode; modulation is AND-gated only in modulated modes
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      low_drv_reg  <= 1'b0;
      high_drv_reg <= 1'b0;
    end
    else
    begin
      low_drv_reg  <= cal_reg[CAL_LO_CONT] |
                      (cal_reg[CAL_LO_MOD] & mon_sync_reg.cal_mod_signal);
      high_drv_reg <= cal_reg[CAL_HI_CONT] |
                      (cal_reg[CAL_HI_MOD] & mon_sync_reg.cal_mod_signal);
    end
  end

  // Analog selection follows the last analog access and holds until the next
  always_comb
  begin
    ana_sel_next = ana_sel_reg;
    if ((reg_rd || reg_wr) && hit_ana)
    begin
      if (reg_addr >= ADDR_ANA_EXT)
      begin
        ana_sel_next.ext_path = 1'b1;
        ana_sel_next.ext_chan = reg_addr[2:0];
      end
      else
      begin
        ana_sel_next.ext_path = 1'b0;
        ana_sel_next.int_chan = ana_offset[3:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ana_sel_reg <= '0;
    end
    else
    begin
      ana_sel_reg <= ana_sel_next;
    end
  end

  // Read multiplexer; analog locations return zero since conversion is off-block
  always_comb
  begin
    rdata_next = '0;
    ack_next   = (reg_rd || reg_wr) && hit_own;
    if (reg_rd)
    begin
      unique case (reg_addr)
        ADDR_CRYO:   rdata_next[2:0]       = cryo_reg;
        ADDR_DMON:   rdata_next[5:0]       = dmon_reg;
        ADDR_CAL:    rdata_next[CAL_W-1:0] = cal_reg;
        ADDR_IDWORD: rdata_next[11:0]      = idword_reg;
        ADDR_SERIAL: rdata_next[SN_W-1:0]  = sn_reg;
        default:     rdata_next            = '0;
      endcase
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_reg <= '0;
      ack_reg   <= 1'b0;
    end
    else
    begin
      rdata_reg <= rdata_next;
      ack_reg   <= ack_next;
    end
  end

  assign reg_rdata       = rdata_reg;
  assign reg_ack         = ack_reg;
  assign id_read_data    = idrd_reg;
  assign id_read_ack     = idack_reg;
  assign cryo_state_bits = cryo_reg;
  assign low_cal_drive   = low_drv_reg;
  assign high_cal_drive  = high_drv_reg;
  assign ana_mux_sel     = ana_sel_reg.int_chan;
  assign ana_ext_path    = ana_sel_reg.ext_path;
  assign ext_mux_select  = ana_sel_reg.ext_chan;

endmodule : femc_frontend_monitor_control

// >>> sim/femc_frontend_monitor_control_checker.sv
`timescale 1ns/100ps
module femc_frontend_monitor_control_checker
  import femc_pkg::*;
(
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              rst_n,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic              reg_ack,
  // Identity port
  input wire logic              id_read_req,
  input wire logic              id_read_ack,
  // Front-end side
  input wire logic [2:0]        cryo_state_bits,
  input wire logic              low_cal_drive,
  input wire logic              high_cal_drive,
  input wire logic              ana_ext_path,
  input wire logic [2:0]        ext_mux_select
);
  logic acc;
  logic mapped;
  logic cryo_wr;
  logic cal_wr;
  assign acc     = reg_wr | reg_rd;
  assign mapped  = reg_addr >= ADDR_ANA_FIRST && reg_addr <= ADDR_SERIAL;
  assign cryo_wr = reg_wr && reg_addr == ADDR_CRYO;
  assign cal_wr  = reg_wr && reg_addr == ADDR_CAL;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_ack_mapped: assert property (acc && mapped |=> reg_ack)
    else $error("mapped access not acknowledged");
  a_ack_unmapped: assert property (acc && !mapped |=> !reg_ack)
    else $error("unmapped access acknowledged");
  a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside read answer");
  a_cryo_write: assert property (cryo_wr |=> cryo_state_bits == $past(reg_wdata[2:0]))
    else $error("cryo outputs miss written value");
  a_cryo_holds: assert property (!cryo_wr |=> $stable(cryo_state_bits))
    else $error("cryo outputs changed without write");
  a_cryo_readback: assert property (reg_rd && reg_addr == ADDR_CRYO
    |=> reg_rdata == {13'h0000, cryo_state_bits})
    else $error("cryo readback differs from latch");
  a_cal_low_cont: assert property (cal_wr && reg_wdata == 16'h0002 ##1 !cal_wr
    |=> low_cal_drive && !high_cal_drive)
    else $error("low continuous drive wrong");
  a_ext_select: assert property (acc && reg_addr[5:3] == 3'h3
    |=> ana_ext_path && ext_mux_select == $past(reg_addr[2:0]))
    else $error("external mux select wrong");
  a_id_answer: assert property (id_read_req |=> id_read_ack)
    else $error("identity read not acknowledged");
endmodule : femc_frontend_monitor_control_checker

bind femc_frontend_monitor_control femc_frontend_monitor_control_checker u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
  .id_read_req(id_read_req), .id_read_ack(id_read_ack), .cryo_state_bits(cryo_state_bits),
  .low_cal_drive(low_cal_drive), .high_cal_drive(high_cal_drive),
  .ana_ext_path(ana_ext_path), .ext_mux_select(ext_mux_select)
);

// >>> sim/femc_fe_model.sv
`timescale 1ns/100ps
module femc_fe_model
  import femc_pkg::*;
#(
  parameter int HALF = 8  // Far shorter than the real 80 Hz so runs stay brief
)
(
  // Clock
  input  wire logic       core_clk,
  // Commands and switch positions
  input  wire logic [2:0] cryo_state_bits,
  input  wire logic [2:0] status,
  // Lines back to the module
  output femc_mon_t       fe_mon
);
  int   cnt = 0;
  logic sq_wave = 1'b0;
  // Free-running square wave
  always @(posedge core_clk)
  begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1)
      sq_wave <= ~sq_wave;
  end
  always_comb
  begin
    fe_mon.cryo_state_monitor = cryo_state_bits;  // Echo of the applied state
    {fe_mon.valve_position_in, fe_mon.pump_request_in, fe_mon.control_source_in} = status;
    fe_mon.band_id_bits = 4'h9;
    fe_mon.fe_serial_bits = 6'h2b;
    fe_mon.fe_mod_level_bits = 2'h2;
    fe_mon.id_parity = ^4'h9;  // Parity over the band bits only
    fe_mon.cal_mod_signal = sq_wave;
  end
endmodule : femc_fe_model

// >>> sim/femc_frontend_monitor_control_bench.sv
`timescale 1ns/100ps
module femc_frontend_monitor_control_bench
  import femc_pkg::*;
();
  logic core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, id_read_req = 1'b0;
  logic [5:0]  reg_addr = 6'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [7:0]  sn_strap = 8'h5a, id_read_data;
  logic [2:0]  status = 3'h0, cryo_state_bits, ext_mux_select;
  logic [3:0]  ana_mux_sel;
  logic        reg_ack, id_read_ack, low_cal_drive, high_cal_drive, ana_ext_path;
  femc_mon_t   fe_mon;
  int n_fail = 0, tests_run = 0, lo_n, hi_n;
  logic [2:0]  cryo_codes[5] = '{CRYO_COOL, CRYO_STRESS, CRYO_OFF, CRYO_HEAT, CRYO_PUMP};
  logic [15:0] cal_codes[5] = '{16'h0000, 16'h0002, 16'h0001, 16'h0008, 16'h0004};
  int lo_exp[5] = '{0, 32, 16, 0, 0};
  int hi_exp[5] = '{0, 0, 0, 32, 16};
  logic [5:0]  ro_addrs[5] = '{ADDR_DMON, ADDR_IDWORD, ADDR_SERIAL, 6'h3f, 6'h02};

  femc_frontend_monitor_control uut (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .id_read_req(id_read_req), .id_read_data(id_read_data), .id_read_ack(id_read_ack),
    .sn_strap(sn_strap), .fe_mon_in(fe_mon), .cryo_state_bits(cryo_state_bits),
    .low_cal_drive(low_cal_drive), .high_cal_drive(high_cal_drive),
    .ana_mux_sel(ana_mux_sel), .ana_ext_path(ana_ext_path), .ext_mux_select(ext_mux_select));
  femc_fe_model fe (.core_clk(core_clk), .cryo_state_bits(cryo_state_bits),
    .status(status), .fe_mon(fe_mon));

  initial
  begin
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Data stand only in the cycle after the strobe, so look just past that edge
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : rd

  task automatic final_report;
    if (n_fail == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report

  initial
  begin
    #50000;
    n_fail++;
    final_report;
  end

  initial
  begin
    repeat (12) @(posedge core_clk);
    chk({cryo_state_bits, low_cal_drive, high_cal_drive}, 5'h00);
    rst_n <= 1'b1;
    rd(ADDR_CRYO, 16'h0000);
    rd(ADDR_CAL, 16'h0000);
    rd(ADDR_SERIAL, 16'h005a);
    chk(reg_ack, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      wr(ADDR_CRYO, {13'h0000, cryo_codes[i % 5]});
      rd(ADDR_CRYO, {13'h0000, cryo_codes[i % 5]});
      chk(cryo_state_bits, cryo_codes[i % 5]);
      @(posedge core_clk);
      status <= i[2:0];
      repeat (4) @(posedge core_clk);
      rd(ADDR_DMON, {10'h000, i[2:0], cryo_codes[i % 5]});
    end
    foreach (ro_addrs[k])
      wr(ro_addrs[k], 16'hffff);
    rd(ADDR_CRYO, {13'h0000, CRYO_OFF});
    rd(ADDR_SERIAL, 16'h005a);
    rd(6'h3f, 16'h0000);
    chk(reg_ack, 1'b0);
    for (int i = 0; i < 5; i++)
    begin
      wr(ADDR_CAL, cal_codes[i]);
      rd(ADDR_CAL, cal_codes[i]);
      repeat (4) @(posedge core_clk);
      lo_n = 0;
      hi_n = 0;
      repeat (32)
      begin
        @(posedge core_clk);
        // Look after the edge so the drive launched by it has settled
        #1;
        lo_n += (low_cal_drive === 1'b1);
        hi_n += (high_cal_drive === 1'b1);
      end
      chk(lo_n, lo_exp[i]);
      chk(hi_n, hi_exp[i]);
    end
    rd(ADDR_IDWORD, 16'h0ae9);
    @(posedge core_clk);
    id_read_req <= 1'b1;
    @(posedge core_clk);
    id_read_req <= 1'b0;
    #1;
    chk({id_read_ack, id_read_data}, {1'b1, 3'h5, ^4'h9, 4'h9});
    rd(6'h0b, 16'h0000);
    chk({ana_ext_path, ana_mux_sel}, 5'h03);
    rd(6'h1d, 16'h0000);
    chk({ana_ext_path, ext_mux_select, ana_mux_sel}, 8'hd3);
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(ADDR_CAL, 16'h0000);
    rd(ADDR_CRYO, 16'h0000);
    final_report;
  end
endmodule : femc_frontend_monitor_control_bench
